// file: shared/timer_channel_params.svh
// constants for the multimode timer channel: offsets, fields, encodings
// assumes a 32-bit apb bus with word-aligned registers
`ifndef TIMER_CHANNEL_PARAMS_SVH
`define TIMER_CHANNEL_PARAMS_SVH

`define TMR_OFS_COUNT    12'h000
`define TMR_OFS_MODE     12'h004
`define TMR_OFS_START    12'h008
`define TMR_OFS_STATUS   12'h00C

// mode register fields
`define MODE_OP_LSB      0
`define MODE_OP_MSB      1
`define MODE_EDGE_LSB    2
`define MODE_EDGE_MSB    3
`define MODE_GATE_BIT    4
`define MODE_GATE_POL    5
`define MODE_PULSE_BIT   6
`define MODE_MEAS_BIT    7
`define MODE_SRC_LSB     8
`define MODE_SRC_MSB     9
`define MODE_WIDTH       10

// mode encodings of bits 1:0
`define OP_INTERVAL      2'h0
`define OP_EVENT         2'h1
`define OP_ONESHOT       2'h2
`define OP_MEASURE       2'h3

// edge select encodings
`define EDGE_RISE        2'h0
`define EDGE_FALL        2'h1
`define EDGE_BOTH        2'h2

// count source encodings
`define SRC_DIV1         2'h0
`define SRC_DIV8         2'h1
`define SRC_DIV32        2'h2
`define SRC_SUB32        2'h3

`define DIV8_LAST        5'h07
`define DIV32_LAST       5'h1F
`define CNT_ZERO         16'h0000
`define CNT_ONES         16'hFFFF
`define STATUS_OVF_BIT   0
`define STATUS_VALID_BIT 1

`endif

// file: shared/timer_channel_pkg.sv
// types shared by the multimode timer channel
// assumes the params header sits on the include path
package timer_channel_pkg;

  typedef enum logic [1:0] {
    OP_INTERVAL_E = 2'h0,
    OP_EVENT_E    = 2'h1,
    OP_ONESHOT_E  = 2'h2,
    OP_MEASURE_E  = 2'h3
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } run_state_t;

endpackage

// file: hw/multimode_timer_channel.sv
// multimode 16-bit timer channel with apb register access
// assumes pins are asynchronous and a subclock tap arrives as a pin level
// Notes on behaviour
// - event mode counts selected pin edges: rising, falling or both
// - event and interval modes count down, reload on underflow
// - underflow period is reload value plus one source events
// - counting runs only while the start flag is set
// - underflow in event or interval mode pulses the interrupt request
// - timer read returns live counter in event and interval modes
// - write while stopped loads reload register and counter
// - write while running loads reload only; counter takes it at reload
// - effective edge captures count into reload and restarts from zero
// - measurement edge raises interrupt, except first edge after start
// - measurement overflow raises interrupt and sets overflow flag
// - overflow flag clears only on mode write while start flag set
// - measurement read returns capture, undefined before second edge
// - measurement mode ignores timer register writes
// - mode bits 1:0 pick interval, event, one-shot or measurement
// - gate option starts and stops counting by pin level in interval mode
// - pulse option toggles pin level at every underflow outside event mode
// - pin is port, gate input or toggle output per option
// - one-shot mode stops at underflow, reloading the counter and clearing the start flag
`timescale 1ns/1ps
`include "timer_channel_params.svh"

module multimode_timer_channel
  import timer_channel_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pins
  input  wire logic              eventCapturePinIn,
  input  wire logic              gateTogglePinIn,
  output logic                   gateTogglePinOut,
  output logic                   gateTogglePinOe,
  input  wire logic              subclkDivThirtytwoIn,
  // interrupt request
  output logic                   timerIrq
);

  // every register of the channel lives in this one struct
  typedef struct packed {
    logic [2:0]            syncEvt;
    logic [2:0]            syncGate;
    logic [2:0]            syncSub;
    logic [4:0]            prescale;
    logic [CNT_W-1:0]      counter;
    logic [CNT_W-1:0]      reload;
    logic [`MODE_WIDTH-1:0] mode;
    logic                  start;
    logic                  overflow;
    logic                  seenEdge;
    logic                  capValid;
    logic                  toggleLevel;
    logic                  irq;
    run_state_t            runState;
    logic [31:0]           rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic              wrEn;
  logic              rdEn;
  logic              addrHit;
  logic              clkDivOne;
  logic              clkDivEight;
  logic              clkDivThirtytwo;
  logic              subclkDivThirtytwo;
  logic              srcTick;
  logic              evtRise;
  logic              evtFall;
  logic              evtEdge;
  logic              gateOpen;
  logic              running;
  logic [1:0]        opMode;
  logic [1:0]        edgeSel;
  logic [1:0]        srcSel;
  logic [CNT_W-1:0]  wrValue;
  logic              isInterval;
  logic              isEvent;
  logic              isOneShot;
  logic              isMeasure;
  logic              measWidth;
  logic              measEdge;
  logic              measTick;
  logic              gateEnabled;
  logic              gateLevelMet;
  logic              countTick;
  logic              underflow;
  logic              ovfSet;
  logic              ovfClear;
  logic              wrMode;
  logic              wrStart;
  logic              startRise;
  logic              pinDrives;
  logic [CNT_W-1:0]  cntDec;
  logic [CNT_W-1:0]  cntInc;
  logic [31:0]       rdNext;

  assign opMode  = cur.mode[`MODE_OP_MSB:`MODE_OP_LSB];
  assign edgeSel = cur.mode[`MODE_EDGE_MSB:`MODE_EDGE_LSB];
  assign srcSel  = cur.mode[`MODE_SRC_MSB:`MODE_SRC_LSB];
  assign wrValue = pwdata[CNT_W-1:0];

  // one decode of the op field, shared by counting, pin and read paths
  assign isInterval = (opMode == `OP_INTERVAL);
  assign isEvent    = (opMode == `OP_EVENT);
  assign isOneShot  = (opMode == `OP_ONESHOT);
  assign isMeasure  = (opMode == `OP_MEASURE);
  assign measWidth  = isMeasure && cur.mode[`MODE_MEAS_BIT];

  // count arithmetic stays at counter width; the up-count wrap is the overflow
  assign cntDec = cur.counter - CNT_W'(1);
  assign cntInc = cur.counter + CNT_W'(1);

  // zero-wait apb: answer in the access phase itself
  assign wrEn    = psel && penable && pwrite;
  // read data is taken at the setup edge so it stands for the whole access
  assign rdEn    = psel && !penable && !pwrite;
  assign addrHit = (paddr == `TMR_OFS_COUNT) || (paddr == `TMR_OFS_MODE)
                || (paddr == `TMR_OFS_START) || (paddr == `TMR_OFS_STATUS);
  assign pready  = 1'b1;
  // unmapped offsets answer with an error but never stall
  assign pslverr = psel && penable && !addrHit;
  assign prdata  = cur.rdata;

  // register write decodes; pstrb is ignored, every register takes a full word
  assign wrMode    = wrEn && (paddr == `TMR_OFS_MODE);
  assign wrStart   = wrEn && (paddr == `TMR_OFS_START);
  assign startRise = wrStart && pwdata[0] && !cur.start;

  // divided source taps as one-cycle enables
  assign clkDivOne          = 1'b1;
  // free-running prescaler: the first tap tick after start may come early
  assign clkDivEight        = (cur.prescale[2:0] == 3'(`DIV8_LAST));
  assign clkDivThirtytwo    = (cur.prescale == `DIV32_LAST);
  // the subclock tap counts its rising edges only, three cycles late
  assign subclkDivThirtytwo = cur.syncSub[1] && !cur.syncSub[2];

  always_comb begin
    case (srcSel)
      `SRC_DIV1:  srcTick = clkDivOne;
      `SRC_DIV8:  srcTick = clkDivEight;
      `SRC_DIV32: srcTick = clkDivThirtytwo;
      default:    srcTick = subclkDivThirtytwo;
    endcase
  end

  // edge detect reads only the second and third stages, never the first
  assign evtRise = cur.syncEvt[1] && !cur.syncEvt[2];
  assign evtFall = !cur.syncEvt[1] && cur.syncEvt[2];

  always_comb begin
    // width measurement takes both edges whatever the edge field says
    if (measWidth) begin
      evtEdge = evtRise || evtFall;
    end else begin
      case (edgeSel)
        `EDGE_RISE: evtEdge = evtRise;
        `EDGE_FALL: evtEdge = evtFall;
        `EDGE_BOTH: evtEdge = evtRise || evtFall;
        default:    evtEdge = evtRise;
      endcase
    end
  end

  // gate level polarity is selectable; pin sampled through synchroniser
  // the gate acts three cycles after the pin moves, like any pin input
  assign gateEnabled  = cur.mode[`MODE_GATE_BIT] && isInterval;
  assign gateLevelMet = (cur.syncGate[1] == cur.mode[`MODE_GATE_POL]);
  assign gateOpen     = !gateEnabled || gateLevelMet;
  assign running      = cur.start && (cur.runState == ST_RUN);

  // in measurement an edge beats a source tick of the same cycle
  assign measEdge = running && isMeasure && evtEdge;
  assign measTick = running && isMeasure && !evtEdge && srcTick;

  // down-count modes step on pin edges in event mode, else on the gated source
  assign countTick = isEvent ? evtEdge : (srcTick && gateOpen);
  assign underflow = countTick && (cur.counter == `CNT_ZERO);

  // overflow set and its software clear in one cycle: the set wins
  assign ovfSet   = measTick && (cur.counter == `CNT_ONES);
  assign ovfClear = wrMode && cur.start;

  always_comb begin
    next_cur = cur;
    next_cur.irq      = 1'b0;
    next_cur.syncEvt  = {cur.syncEvt[1:0], eventCapturePinIn};
    next_cur.syncGate = {cur.syncGate[1:0], gateTogglePinIn};
    next_cur.syncSub  = {cur.syncSub[1:0], subclkDivThirtytwoIn};
    next_cur.prescale = cur.prescale + 5'h01;

    // start flag sequencing; one-shot passes through done for one cycle, then idle
    case (cur.runState)
      ST_IDLE: begin
        if (cur.start) begin
          next_cur.runState = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!cur.start) begin
          next_cur.runState = ST_IDLE;
        end
      end
      ST_DONE: begin
        if (!cur.start) begin
          next_cur.runState = ST_IDLE;
        end
      end
      default: next_cur.runState = ST_IDLE;
    endcase

    if (running) begin
      case (opMode)
        `OP_INTERVAL, `OP_EVENT, `OP_ONESHOT: begin
          if (countTick) begin
            if (underflow) begin
              // a running write waits in the reload copy until this point
              next_cur.counter = cur.reload;
              next_cur.irq     = 1'b1;
              // toggle level survives a stop, so a restart resumes from it
              if (cur.mode[`MODE_PULSE_BIT] && !isEvent) begin
                next_cur.toggleLevel = !cur.toggleLevel;
              end
              // done marks a finished one-shot; start is cleared here, so idle follows next cycle
              if (isOneShot) begin
                next_cur.runState = ST_DONE;
                next_cur.start    = 1'b0;
              end
            end else begin
              next_cur.counter = cntDec;
            end
          end
        end
        default: begin
          // the capture stays undefined to software until a second edge
          if (measEdge) begin
            next_cur.reload   = cur.counter;
            next_cur.counter  = `CNT_ZERO;
            next_cur.seenEdge = 1'b1;
            next_cur.capValid = cur.seenEdge;
            next_cur.irq      = cur.seenEdge;
          end else if (srcTick) begin
            next_cur.counter = cntInc;
            if (ovfSet) begin
              next_cur.overflow = 1'b1;
              next_cur.irq      = 1'b1;
            end
          end
        end
      endcase
    end

    // register writes; hardware overflow set wins over the clear
    if (wrEn) begin
      case (paddr)
        `TMR_OFS_COUNT: begin
          // dropped silently in measurement, with no slave error
          if (!isMeasure) begin
            next_cur.reload = wrValue;
            if (!running) begin
              next_cur.counter = wrValue;
            end
          end
        end
        `TMR_OFS_MODE: begin
          next_cur.mode = pwdata[`MODE_WIDTH-1:0];
          if (ovfClear && !ovfSet) begin
            next_cur.overflow = 1'b0;
          end
        end
        `TMR_OFS_START: begin
          next_cur.start = pwdata[0];
          if (startRise) begin
            next_cur.seenEdge = 1'b0;
            next_cur.capValid = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (rdEn) begin
      next_cur.rdata = rdNext;
    end
  end

  // read mux apart from the state update; upper bits read zero
  always_comb begin
    rdNext = 32'h0000_0000;
    case (paddr)
      `TMR_OFS_COUNT:  rdNext[CNT_W-1:0] = isMeasure ? cur.reload : cur.counter;
      `TMR_OFS_MODE:   rdNext[`MODE_WIDTH-1:0] = cur.mode;
      `TMR_OFS_START:  rdNext[0] = cur.start;
      `TMR_OFS_STATUS: begin
        rdNext[`STATUS_OVF_BIT]   = cur.overflow;
        rdNext[`STATUS_VALID_BIT] = cur.capValid;
      end
      default:         rdNext = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{runState: ST_IDLE, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // pin drives only when pulse output is chosen outside measurement/event
  // and stays an input while gated, so the gate level is never overdriven
  assign pinDrives        = cur.mode[`MODE_PULSE_BIT] && !cur.mode[`MODE_GATE_BIT]
                         && (isInterval || isOneShot);
  assign gateTogglePinOe  = pinDrives;
  assign gateTogglePinOut = cur.toggleLevel;
  // a one-cycle registered pulse; a wider request needs a latch outside
  assign timerIrq         = cur.irq;

endmodule

// file: test/pulse_source.sv
// pulse source on the capture pin: n full periods, rise first
// assumes go is held one cycle; pin idles low between bursts
`timescale 1ns/1ps
module pulse_source (
  // control
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] nPulse,
  input  wire logic [7:0] halfPer,
  // pin side
  output logic            pin,
  output logic            busy
);
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  always @(posedge core_clk) begin
    if (go) begin
      busy <= 1'b1;
      for (int k = 0; k < 2 * nPulse; k++) begin
        repeat (halfPer) @(posedge core_clk);
        pin <= ~pin;
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: test/multimode_timer_channel_props.sv
// port assertions for the multimode timer channel
// assumes apb writes land at the access edge; mode and start are shadowed
`timescale 1ns/1ps
module multimode_timer_channel_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin and request
  input wire logic        gateTogglePinOe,
  input wire logic        timerIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [9:0] mode;
  logic       start;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic       drv;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C};
  // shadow misses the one-shot self clear, which only weakens a_irq_start
  assign drv = mode[6] && !mode[4] && !mode[0];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= 10'h000;
      start <= 1'b0;
    end else if (wr && paddr == 12'h004) begin
      mode <= pwdata[9:0];
    end else if (wr && paddr == 12'h008) begin
      start <= pwdata[0];
    end
  end
  property p_err_phase;
    pslverr |-> acc;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_unmapped;
    acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access stalled");
  property p_hold;
    !$past(psel && !penable && !pwrite) |-> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_irq_start;
    timerIrq |-> $past(start) || $past(start, 2);
  endproperty
  a_irq_start: assert property (p_irq_start) else $error("request while stopped");
  property p_irq_pulse;
    timerIrq && mode[1:0] == 2'h1 |=> !timerIrq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request too long");
  property p_oneshot;
    timerIrq && mode[1:0] == 2'h2 |=> (!timerIrq)[*8] or ##[0:7] (wr && paddr == 12'h008);
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept going");
  property p_oe;
    drv == $past(drv) |-> gateTogglePinOe == drv;
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive wrong");
endmodule
bind multimode_timer_channel multimode_timer_channel_props i_multimode_timer_channel_props (
  .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .gateTogglePinOe, .timerIrq);

// file: test/multimode_timer_channel_tb_top.sv
// bench for the multimode timer channel: apb tasks and pulse bursts
// assumes a zero-wait slave; pin edges act a few cycles late
`timescale 1ns/1ps
module multimode_timer_channel_tb_top;
  logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, go;
  logic        gateIn, gateWire, pinOut, pinOe, timerIrq, pin, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cap;
  logic [7:0]  nPulse, halfPer;
  int          n_fail, cmp_count, irqs, k;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (timerIrq === 1'b1) irqs++;
  assign gateWire = pinOe ? pinOut : gateIn;
  multimode_timer_channel i_multimode_timer_channel (.core_clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .eventCapturePinIn(pin), .gateTogglePinIn(gateWire), .gateTogglePinOut(pinOut),
    .gateTogglePinOe(pinOe), .subclkDivThirtytwoIn(1'b0), .timerIrq);
  pulse_source i_pulse_source (.core_clk, .go, .nPulse, .halfPer, .pin, .busy);
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic pulses(input logic [7:0] n, input logic [7:0] h);
    nPulse <= n;
    halfPer <= h;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (busy && k < 3000);
    chk(32'(k < 3000), 32'h0000_0001);
    // let the pin synchroniser drain
    repeat (6) @(posedge core_clk);
  endtask
  task automatic gap(output int n);
    logic v;
    v = pinOut;
    n = 0;
    while (pinOut === v && n < 40) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  initial begin
    {core_clk, arst_n, psel, penable, pwrite, go, gateIn} = 7'h00;
    {paddr, pwdata, nPulse, halfPer} = 60'h0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1, 12'h000, 16'h1234);
    apb(0, 12'h000, 16'h0000); chk(rd, 32'h0000_1234);
    apb(0, 12'h010, 16'h0000); chk(rd, 32'h0000_0000);
    // rising, falling, both: three pulses from reload two
    for (int e = 0; e < 3; e++) begin
      apb(1, 12'h004, 16'(4 * e + 1));
      apb(1, 12'h000, 16'h0002);
      apb(1, 12'h008, 16'h0001);
      irqs = 0;
      pulses(8'h03, 8'h03);
      chk(32'(irqs), (e == 2) ? 32'h0000_0002 : 32'h0000_0001);
      apb(0, 12'h000, 16'h0000); chk(rd, 32'h0000_0002);
      apb(1, 12'h008, 16'h0000);
    end
    apb(1, 12'h004, 16'h0001);
    apb(1, 12'h008, 16'h0001);
    apb(1, 12'h000, 16'h0005);
    apb(0, 12'h000, 16'h0000); chk(rd, 32'h0000_0002);
    pulses(8'h03, 8'h03);
    apb(0, 12'h000, 16'h0000); chk(rd, 32'h0000_0005);
    apb(1, 12'h008, 16'h0000);
    irqs = 0;
    pulses(8'h02, 8'h03);
    apb(0, 12'h000, 16'h0000); chk(rd + 32'(irqs), 32'h0000_0005);
    // interval with toggle output, div1, reload three
    apb(1, 12'h004, 16'h0040);
    apb(1, 12'h000, 16'h0003);
    apb(1, 12'h008, 16'h0001);
    gap(k);
    gap(k);
    chk(32'(k), 32'h0000_0004);
    chk(32'(pinOe), 32'h0000_0001);
    apb(1, 12'h008, 16'h0000);
    // period then width measurement of the same 20-cycle spacing
    apb(1, 12'h004, 16'h0003);
    apb(1, 12'h008, 16'h0001);
    irqs = 0;
    pulses(8'h04, 8'h0A);
    chk(32'(irqs), 32'h0000_0003);
    apb(0, 12'h000, 16'h0000);
    cap = rd;
    apb(1, 12'h000, 16'hAAAA);
    apb(0, 12'h000, 16'h0000); chk(rd, cap);
    apb(0, 12'h00C, 16'h0000); chk(32'(rd[1]), 32'h0000_0001);
    apb(1, 12'h008, 16'h0000);
    apb(1, 12'h004, 16'h0083);
    apb(1, 12'h008, 16'h0001);
    irqs = 0;
    pulses(8'h02, 8'h14);
    chk(32'(irqs), 32'h0000_0003);
    apb(0, 12'h000, 16'h0000); chk(rd, cap);
    irqs = 0;
    k = 0;
    while (irqs == 0 && k < 70000) begin
      @(posedge core_clk);
      k++;
    end
    chk(32'(irqs), 32'h0000_0001);
    apb(1, 12'h008, 16'h0000);
    apb(1, 12'h004, 16'h0083);
    apb(0, 12'h00C, 16'h0000); chk(32'(rd[0]), 32'h0000_0001);
    apb(1, 12'h008, 16'h0001);
    apb(1, 12'h004, 16'h0083);
    apb(0, 12'h00C, 16'h0000); chk(32'(rd[0]), 32'h0000_0000);
    apb(1, 12'h008, 16'h0000);
    apb(1, 12'h004, 16'h0002);
    apb(1, 12'h000, 16'h0003);
    irqs = 0;
    apb(1, 12'h008, 16'h0001);
    repeat (30) @(posedge core_clk);
    chk(32'(irqs), 32'h0000_0001);
    apb(0, 12'h008, 16'h0000); chk(32'(rd[0]), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
